//--- pkg/mcc_pkg.sv
`default_nettype none
package mcc_pkg;

   // ************************************************************
   // Widths and slot geometry
   // ************************************************************
   localparam int DATA_W = 32;
   localparam int OP_W = 16;
   localparam int SLOT_COUNT = 4;
   localparam int WORD_COUNT = 4;
   // mul_operand_a, div_dividend, filter_sample_in
   localparam int WORD_OP_A = 0;
   // mul_operand_b, div_divisor, filter_coeff
   localparam int WORD_OP_B = 1;
   // mul_product, div_quotient, filter_output
   localparam int WORD_RES1 = 2;
   // div_remainder
   localparam int WORD_RES2 = 3;

   // ************************************************************
   // Control register layout and reset values
   // ************************************************************
   localparam int BUSY_BIT = 7;
   localparam int LAUNCH_MSB = 6;
   localparam int LAUNCH_LSB = 3;
   localparam int MODE_MSB = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // ************************************************************
   // Arithmetic and timing constants
   // ************************************************************
   // Coefficient is a Q15 fraction
   localparam int FILT_SHIFT = 15;
   localparam int DIV_STEPS = 32;
   // Longest engine run, in cycles, used by a check
   localparam logic [5:0] RUN_LIMIT = 6'h28;

   // ************************************************************
   // Enumerations
   // ************************************************************
   typedef enum logic [2:0]
   {
      MODE_MUL_SHL = 3'h0,
      MODE_MUL_S = 3'h1,
      MODE_MUL_U = 3'h2,
      MODE_DIV = 3'h3,
      MODE_ROT = 3'h4,
      MODE_ATAN = 3'h5,
      MODE_FILT = 3'h6,
      MODE_PID = 3'h7
   } mcc_mode_type;

   typedef enum logic [3:0]
   {
      ENG_IDLE = 4'h1,
      ENG_FETCH = 4'h2,
      ENG_EXEC = 4'h4,
      ENG_DIV = 4'h8
   } mcc_eng_state_type;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed
   {
      logic wr;
      logic [7:0] wdata;
   } mcc_ctrl_req_type;

   typedef struct packed
   {
      logic we;
      logic [1:0] slot;
      logic [1:0] sel;
      logic [31:0] wdata;
   } mcc_data_req_type;

   typedef struct packed
   {
      logic we1;
      logic we2;
      logic [1:0] slot;
      logic [31:0] res1;
      logic [31:0] res2;
   } mcc_eng_wr_type;

   typedef struct packed
   {
      mcc_eng_state_type st;
      logic [3:0] pend;
      logic [3:0][2:0] pmode;
      logic [1:0] slot;
      logic [2:0] mode;
      logic div_go;
      logic [7:0] ctrl;
      mcc_eng_wr_type wr;
   } mcc_core_state_type;

   localparam mcc_core_state_type CORE_RESET = '{
      st: ENG_IDLE, pend: 4'h0, pmode: '0, slot: 2'h0, mode: 3'h0,
      div_go: 1'b0, ctrl: CTRL_RESET, wr: '0};

endpackage
`default_nettype wire

//--- tb/mcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Host driver, one request set per falling edge
// ******************************
module mcc_host_model
(
   // Clock
   input wire logic clk,
   // Requests toward the core
   output logic [8:0] ctrl_req,
   output logic [36:0] data_req,
   // High while the read answer stands
   output logic rd_ok
);
   // Idle from time zero so no strobe is seen
   initial
   begin
      ctrl_req = '0;
      data_req = '0;
      rd_ok = 1'b0;
   end
   // One cycle of requests; each strobe lasts one cycle
   task automatic cyc(input logic cw, input logic [7:0] cd,
      input logic we, input logic [1:0] s, input logic [1:0] sel,
      input logic [31:0] wd, input logic ok);
      @(negedge clk);
      ctrl_req = {cw, cd};
      data_req = {we, s, sel, wd};
      rd_ok = ok;
   endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Core ports
   logic clk;
   logic rst_n;
   mcc_pkg::mcc_ctrl_req_type ctrl_req;
   mcc_pkg::mcc_data_req_type data_req;
   logic [7:0] ctrl_img;
   logic busy;
   logic [31:0] data_rdata;
   logic rd_ok;
   // Scoring and stored expectations
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;
   integer seed = 32'h826D32BB;
   logic [31:0] exp_q[$];
   logic [63:0] res[4];
   logic [31:0] oa[4];
   logic [31:0] ob[4];
   logic [2:0] modes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
   mcc_host_model host_u (.clk(clk), .ctrl_req(ctrl_req),
      .data_req(data_req), .rd_ok(rd_ok));
   mcc_core dut_u (.clk(clk), .rst_n(rst_n), .ctrl_req(ctrl_req),
      .coproc_control_reg(ctrl_img), .calc_busy_flag(busy),
      .data_req(data_req), .data_rdata(data_rdata));
   // ******************************
   // Reference arithmetic, {second result, first result}
   // ******************************
   function automatic logic [63:0] calc(input logic [2:0] m,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] y);
      logic signed [31:0] ps;
      longint t;
      ps = $signed(a[15:0]) * $signed(b[15:0]);
      t = longint'($signed(b[15:0])) *
         (longint'($signed(a[15:0])) - longint'($signed(y)));
      case (m)
         3'h0: return {32'h0, ps << 1};
         3'h1: return {32'h0, ps};
         3'h2: return {32'h0, {16'h0, a[15:0]} * {16'h0, b[15:0]}};
         3'h3: return {16'h0, 16'(a % {16'h0, b[15:0]}),
            a / {16'h0, b[15:0]}};
         3'h6: return {32'h0, y + 32'(t >>> 15)};
         default: return 64'h0;
      endcase
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Counts: %0d compared, %0d failed", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Host request shapes
   task automatic idle();
      host_u.cyc(1'b0, 8'h00, 1'b0, 2'h0, 2'h0, 32'h0, 1'b0);
   endtask
   task automatic wr_ctl(input logic [7:0] c);
      host_u.cyc(1'b1, c, 1'b0, 2'h0, 2'h0, 32'h0, 1'b0);
   endtask
   task automatic wr_word(input logic [1:0] s, input logic [1:0] sel,
      input logic [31:0] d);
      host_u.cyc(1'b0, 8'h00, 1'b1, s, sel, d, 1'b0);
   endtask
   // Expectation queued; the monitor judges the answer
   task automatic rd(input logic [1:0] s, input logic [1:0] sel,
      input logic [31:0] e);
      exp_q.push_back(e);
      host_u.cyc(1'b0, 8'h00, 1'b0, s, sel, 32'h0, 1'b0);
      host_u.cyc(1'b0, 8'h00, 1'b0, s, sel, 32'h0, 1'b1);
   endtask
   // Bounded poll; division is the longest run
   task automatic wait_idle();
      for (int i = 0; i < 60 && busy !== 1'b0; i++)
         idle();
      cmp(32'(busy), 32'h0);
   endtask
   // Read monitor, looks once the answer has settled
   always @(negedge clk)
   begin
      #1;
      if (rd_ok === 1'b1)
         cmp(data_rdata, exp_q.pop_front());
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      logic [31:0] a, b, y;
      logic [1:0] s;
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      cmp({24'h0, ctrl_img}, 32'h0);
      rd(2'h3, 2'h2, 32'h0);
      foreach (modes[i])
      begin
         s = modes[i][1:0];
         a = $random(seed);
         b = $random(seed) | 32'h1;
         y = 32'($signed(b[31:8]));
         oa[s] = a;
         ob[s] = b;
         res[s] = calc(modes[i], a, b, y);
         wr_ctl({5'h0, modes[i]});
         wr_word(s, 2'h0, a);
         wr_word(s, 2'h1, b);
         if (modes[i] == 3'h6)
            wr_word(s, 2'h2, y);
         wr_ctl({1'b0, 4'h1 << s, modes[i]});
         idle();
         cmp(32'(busy), 32'h1);
         wait_idle();
         cmp({24'h0, ctrl_img}, {25'h0, 4'h1 << s, modes[i]});
         rd(s, 2'h2, res[s][31:0]);
         if (modes[i] == 3'h3)
            rd(s, 2'h3, res[s][63:32]);
      end
      // Two launch bits: kept, but nothing starts
      wr_ctl(8'h19);
      idle();
      idle();
      cmp({busy, 24'h0, ctrl_img[6:0]}, 32'h19);
      wr_ctl(8'h80);
      idle();
      cmp({24'h0, ctrl_img}, 32'h0);
      // Back to back launches in two slots
      wr_ctl(8'h09);
      wr_ctl(8'h12);
      wait_idle();
      // Unbuilt modes end the run and leave the words alone
      wr_ctl(8'h14);
      wr_ctl(8'h0F);
      wait_idle();
      cmp({24'h0, ctrl_img}, 32'h0F);
      res[0] = calc(3'h1, oa[0], ob[0], 32'h0);
      res[1] = calc(3'h2, oa[1], ob[1], 32'h0);
      rd(2'h0, 2'h2, res[0][31:0]);
      rd(2'h1, 2'h2, res[1][31:0]);
      rd(2'h3, 2'h2, res[3][31:0]);
      rd(2'h3, 2'h3, res[3][63:32]);
      rd(2'h3, 2'h0, oa[3]);
      rd(2'h2, 2'h2, res[2][31:0]);
      idle();
      // Reset while idle clears the image and the words
      rst_n = 1'b0;
      idle();
      rst_n = 1'b1;
      cmp({24'h0, ctrl_img}, 32'h0);
      rd(2'h3, 2'h2, 32'h0);
      idle();
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- verilog/mcc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Busy clears by itself when run finishes
// - Mode 000: signed product shifted left once
// - Mode 001: plain signed 16x16 product
// - Mode 010: unsigned 16x16 product, 32 bits
// - Multiplicand A, multiplier B, product to result
// - Mode 011: 32/16 unsigned quotient and remainder
// - Division reads two inputs, writes two results
// - Mode 110: filter step updates output word
// - Filter output 32-bit signed, inputs 16-bit
// - Separate slots stay independent, nesting allowed
// - Launch field one-hot, starts slots zero-three
// - Busy bit 7, launch 6:3, mode 2:0
module mcc_core
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control register port
   input wire mcc_pkg::mcc_ctrl_req_type ctrl_req,
   output logic [7:0] coproc_control_reg,
   output logic calc_busy_flag,
   // Slot data register port
   input wire mcc_pkg::mcc_data_req_type data_req,
   output logic [31:0] data_rdata
);

   // ************************************************************
   // State and internal signals
   // ************************************************************
   mcc_pkg::mcc_core_state_type state_r;
   mcc_pkg::mcc_core_state_type state_nxt;
   logic [3:0][31:0] slot_words; // Slot being computed
   logic div_done; // Divider finished pulse
   logic [31:0] div_q;
   logic [15:0] div_r;
   logic [1:0] pick; // Lowest pending slot
   logic [3:0] launch_field; // Written slot_launch_select
   logic [1:0] launch_idx;
   logic launch_ok; // Exactly one bit set
   logic [2:0] calc_mode_select; // Written mode field
   logic [5:0] run_cnt_r; // Check only

   // Datapath operands and results
   logic signed [15:0] op_a16;
   logic signed [15:0] op_b16;
   logic [31:0] op_y;
   logic signed [31:0] prod_s;
   logic [31:0] prod_u;
   logic signed [32:0] filt_diff;
   logic signed [48:0] filt_scaled;
   logic [31:0] filt_new;
   logic signed [31:0] chk_s; // Check only
   logic signed [63:0] filt_chk; // Check only

   // ************************************************************
   // Helpers
   // ************************************************************
   // Index of the lowest set bit; zero when none
   function automatic logic [1:0] low_index(input logic [3:0] v);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = 3; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // ************************************************************
   // Launch decode
   // ************************************************************
   assign launch_field = ctrl_req.wdata[mcc_pkg::LAUNCH_MSB:
                                        mcc_pkg::LAUNCH_LSB];
   assign calc_mode_select = ctrl_req.wdata[mcc_pkg::MODE_MSB:0];
   assign launch_ok = (launch_field != 4'h0) &&
                      ((launch_field & (launch_field - 4'h1)) == 4'h0);
   assign launch_idx = low_index(launch_field);
   // Fixed priority: lower slot served first when several wait
   assign pick = low_index(state_r.pend);

   // ************************************************************
   // Arithmetic
   // ************************************************************
   // A is multiplicand, B multiplier
   assign op_a16 = slot_words[mcc_pkg::WORD_OP_A][15:0];
   assign op_b16 = slot_words[mcc_pkg::WORD_OP_B][15:0];
   assign op_y = slot_words[mcc_pkg::WORD_RES1];
   assign prod_s = op_a16 * op_b16;
   assign prod_u = slot_words[mcc_pkg::WORD_OP_A][15:0] *
                   slot_words[mcc_pkg::WORD_OP_B][15:0];
   // signed 16-bit sample and coefficient, 32-bit output
   assign filt_diff = 33'(op_a16) - 33'($signed(op_y));
   assign filt_scaled = 49'(op_b16) * 49'(filt_diff);
   // output plus scaled difference, wraps at 32 bits
   assign filt_new = op_y + filt_scaled[mcc_pkg::FILT_SHIFT +:
                                        mcc_pkg::DATA_W];

   // ************************************************************
   // Engine and control register
   // ************************************************************
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.div_go = 1'b0;
      state_nxt.wr.we1 = 1'b0;
      state_nxt.wr.we2 = 1'b0;
      unique case (state_r.st)
         // Take one waiting slot
         mcc_pkg::ENG_IDLE:
         begin
            if (|state_r.pend)
            begin
               // each run bound to its own slot
               state_nxt.slot = pick;
               state_nxt.mode = state_r.pmode[pick];
               state_nxt.pend[pick] = 1'b0;
               state_nxt.st = mcc_pkg::ENG_FETCH;
            end
         end
         // Store reads the whole slot
         mcc_pkg::ENG_FETCH:
         begin
            state_nxt.st = mcc_pkg::ENG_EXEC;
         end
         // Compute in one cycle, except division
         mcc_pkg::ENG_EXEC:
         begin
            state_nxt.wr.slot = state_r.slot;
            state_nxt.st = mcc_pkg::ENG_IDLE;
            unique case (state_r.mode)
               mcc_pkg::MODE_MUL_SHL:
               begin
                  state_nxt.wr.we1 = 1'b1;
                  state_nxt.wr.res1 = {prod_s[30:0], 1'b0};
               end
               mcc_pkg::MODE_MUL_S:
               begin
                  state_nxt.wr.we1 = 1'b1;
                  state_nxt.wr.res1 = prod_s;
               end
               mcc_pkg::MODE_MUL_U:
               begin
                  state_nxt.wr.we1 = 1'b1;
                  state_nxt.wr.res1 = prod_u;
               end
               mcc_pkg::MODE_DIV:
               begin
                  state_nxt.div_go = 1'b1;
                  state_nxt.st = mcc_pkg::ENG_DIV;
               end
               mcc_pkg::MODE_FILT:
               begin
                  // new output over the old one
                  state_nxt.wr.we1 = 1'b1;
                  state_nxt.wr.res1 = filt_new;
               end
               mcc_pkg::MODE_ROT, mcc_pkg::MODE_ATAN, mcc_pkg::MODE_PID:
               begin
                  // Not built here: finish without touching results
                  state_nxt.st = mcc_pkg::ENG_IDLE;
               end
            endcase
         end
         // Wait for the serial divider
         mcc_pkg::ENG_DIV:
         begin
            if (div_done)
            begin
               // quotient and remainder to two words
               state_nxt.wr.we1 = 1'b1;
               state_nxt.wr.we2 = 1'b1;
               state_nxt.wr.res1 = div_q;
               state_nxt.wr.res2 = {16'h0000, div_r};
               state_nxt.st = mcc_pkg::ENG_IDLE;
            end
         end
      endcase
      // Launch last, so a new launch beats the take-clear
      if (ctrl_req.wr)
      begin
         // launch and mode fields read back
         state_nxt.ctrl[6:0] = ctrl_req.wdata[6:0];
         if (launch_ok)
         begin
            // mode comes from the same write as the launch
            state_nxt.pend[launch_idx] = 1'b1;
            state_nxt.pmode[launch_idx] = calc_mode_select;
         end
      end
      // busy drops once queue, run and store write are done
      state_nxt.ctrl[mcc_pkg::BUSY_BIT] = (|state_nxt.pend) ||
         (state_nxt.st != mcc_pkg::ENG_IDLE) ||
         state_nxt.wr.we1 || state_nxt.wr.we2;
   end

   // Register engine state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= mcc_pkg::CORE_RESET;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // busy sits in bit 7 of the image
   assign coproc_control_reg = state_r.ctrl;
   assign calc_busy_flag = state_r.ctrl[mcc_pkg::BUSY_BIT];

   // ************************************************************
   // Slot store and divider
   // ************************************************************
   mcc_slot_mem u_store
   (
      .clk(clk),
      .rst_n(rst_n),
      .host_req(data_req),
      .host_rdata(data_rdata),
      .eng_slot(state_r.slot),
      .eng_words(slot_words),
      .eng_wr(state_r.wr)
   );

   mcc_divider u_div
   (
      .clk(clk),
      .rst_n(rst_n),
      .start(state_r.div_go),
      .dividend(slot_words[mcc_pkg::WORD_OP_A]),
      .divisor(slot_words[mcc_pkg::WORD_OP_B][15:0]),
      .done(div_done),
      .quotient(div_q),
      .remainder(div_r)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   assign chk_s = 32'(op_a16) * 32'(op_b16);
   assign filt_chk = 64'($signed(op_y)) +
      ((64'(op_b16) * (64'(op_a16) - 64'($signed(op_y)))) >>> 15);

   // Length of the current engine run
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_cnt_r <= 6'h00;
      end
      else if (state_r.st == mcc_pkg::ENG_IDLE)
      begin
         run_cnt_r <= 6'h00;
      end
      else if (run_cnt_r != 6'h3F)
      begin
         run_cnt_r <= run_cnt_r + 6'h01;
      end
   end

   a_run_bounded:
   assert property (@(posedge clk) disable iff (!rst_n)
      run_cnt_r <= mcc_pkg::RUN_LIMIT)
   else $error("engine run too long");

   a_busy_launch:
   assert property (@(posedge clk) disable iff (!rst_n)
      (ctrl_req.wr && launch_ok) |=> calc_busy_flag)
   else $error("launch did not set busy");

   // invalid launch on idle block starts no run
   a_bad_launch:
   assert property (@(posedge clk) disable iff (!rst_n)
      (ctrl_req.wr && !launch_ok && !calc_busy_flag) |=> !calc_busy_flag)
   else $error("non one-hot launch started a run");

   a_ctrl_fields:
   assert property (@(posedge clk) disable iff (!rst_n)
      ctrl_req.wr |=> coproc_control_reg[6:0] == $past(ctrl_req.wdata[6:0]))
   else $error("control fields not stored");

   a_mul_shift:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.st == mcc_pkg::ENG_EXEC && state_r.mode == 3'h0) |=>
      (state_r.wr.we1 && state_r.wr.res1 == ($past(chk_s) <<< 1)))
   else $error("shifted product wrong");

   a_mul_signed:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.st == mcc_pkg::ENG_EXEC && state_r.mode == 3'h1) |=>
      (state_r.wr.we1 && $signed(state_r.wr.res1) == $past(chk_s)))
   else $error("signed product wrong");

   a_mul_unsigned:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.st == mcc_pkg::ENG_EXEC && state_r.mode == 3'h2) |=>
      (state_r.wr.we1 && state_r.wr.res1 ==
       $past({16'h0000, op_a16} * {16'h0000, op_b16})))
   else $error("unsigned product wrong");

   // product only to this slot's result word
   a_mul_dest:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.st == mcc_pkg::ENG_EXEC && state_r.mode < 3'h3) |=>
      (!state_r.wr.we2 && state_r.wr.slot == $past(state_r.slot)))
   else $error("product stored to wrong place");

   a_div_store:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.st == mcc_pkg::ENG_DIV && div_done) |=>
      (state_r.wr.we1 && state_r.wr.we2 &&
       state_r.wr.res1 == $past(div_q) &&
       state_r.wr.res2[15:0] == $past(div_r)))
   else $error("division results not stored");

   a_filt_step:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.st == mcc_pkg::ENG_EXEC && state_r.mode == 3'h6) |=>
      (state_r.wr.we1 && state_r.wr.res1 == $past(filt_chk[31:0])))
   else $error("filter step wrong");

   // taken slot is the lowest waiting one
   a_slot_taken:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.st == mcc_pkg::ENG_IDLE && |state_r.pend) |=>
      (state_r.st == mcc_pkg::ENG_FETCH &&
       (($past(state_r.pend) >> state_r.slot) & 4'h1) == 4'h1 &&
       ($past(state_r.pend) & ((4'h1 << state_r.slot) - 4'h1)) == 4'h0))
   else $error("wrong slot taken");

   c_mul_done: cover property (@(posedge clk) disable iff (!rst_n)
      state_r.st == mcc_pkg::ENG_EXEC && state_r.mode == 3'h1);
   c_div_done: cover property (@(posedge clk) disable iff (!rst_n)
      state_r.st == mcc_pkg::ENG_DIV && div_done);
   c_filt_done: cover property (@(posedge clk) disable iff (!rst_n)
      state_r.st == mcc_pkg::ENG_EXEC && state_r.mode == 3'h6);
   c_nested: cover property (@(posedge clk) disable iff (!rst_n)
      calc_busy_flag && ctrl_req.wr && launch_ok);

endmodule
`default_nettype wire

//--- verilog/mcc_divider.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_divider
#(
   parameter int DVD_W = 32,
   parameter int DVS_W = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Operands
   input wire logic start,
   input wire logic [DVD_W-1:0] dividend,
   input wire logic [DVS_W-1:0] divisor,
   // Results
   output logic done,
   output logic [DVD_W-1:0] quotient,
   output logic [DVS_W-1:0] remainder
);

   // ************************************************************
   // Restoring divider, one quotient bit per cycle
   // ************************************************************
   typedef struct packed
   {
      logic [5:0] cnt; // Steps taken
      logic run;
      logic done;
      logic [DVD_W-1:0] q; // Dividend shifts out, quotient in
      logic [DVS_W:0] r; // Partial remainder
      logic [DVS_W-1:0] d;
   } mcc_div_state_type;

   mcc_div_state_type state_r;
   mcc_div_state_type state_nxt;
   logic [DVD_W-1:0] dvd_keep_r; // Check only

   // Step; divisor zero gives all-ones quotient, no trap
   always_comb
   begin
      logic [DVS_W:0] shifted;
      shifted = {state_r.r[DVS_W-1:0], state_r.q[DVD_W-1]};
      state_nxt = state_r;
      state_nxt.done = 1'b0;
      if (start)
      begin
         state_nxt.q = dividend;
         state_nxt.r = '0;
         state_nxt.d = divisor;
         state_nxt.cnt = 6'h00;
         state_nxt.run = 1'b1;
      end
      else if (state_r.run)
      begin
         if (shifted >= {1'b0, state_r.d})
         begin
            state_nxt.r = shifted - {1'b0, state_r.d};
            state_nxt.q = {state_r.q[DVD_W-2:0], 1'b1};
         end
         else
         begin
            state_nxt.r = shifted;
            state_nxt.q = {state_r.q[DVD_W-2:0], 1'b0};
         end
         state_nxt.cnt = state_r.cnt + 6'h01;
         if (state_r.cnt == 6'(mcc_pkg::DIV_STEPS - 1))
         begin
            state_nxt.run = 1'b0;
            state_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= '0;
         dvd_keep_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (start)
         begin
            dvd_keep_r <= dividend;
         end
      end
   end

   assign done = state_r.done;
   assign quotient = state_r.q;
   assign remainder = state_r.r[DVS_W-1:0];

   a_div_identity:
   assert property (@(posedge clk) disable iff (!rst_n)
      (state_r.done && state_r.d != '0) |->
      ((48'(state_r.q) * 48'(state_r.d) + 48'(state_r.r[DVS_W-1:0])
        == 48'(dvd_keep_r)) && (state_r.r[DVS_W-1:0] < state_r.d)))
   else $error("division result inconsistent");

   a_div_latency:
   assert property (@(posedge clk) disable iff (!rst_n)
      (start && !state_r.run) |-> ##33 state_r.done)
   else $error("division did not finish in 33 cycles");

endmodule
`default_nettype wire

//--- verilog/mcc_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_slot_mem
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host side
   input wire mcc_pkg::mcc_data_req_type host_req,
   output logic [31:0] host_rdata,
   // Engine side
   input wire logic [1:0] eng_slot,
   output logic [3:0][31:0] eng_words,
   input wire mcc_pkg::mcc_eng_wr_type eng_wr
);

   // ************************************************************
   // Storage state
   // ************************************************************
   typedef struct packed
   {
      logic [15:0][31:0] mem; // Four slots of four words
      logic [31:0] hrd; // Host read register
      logic [3:0][31:0] erd; // Whole-slot read register
   } mcc_mem_state_type;

   mcc_mem_state_type state_r;
   mcc_mem_state_type state_nxt;

   // Word update; engine writes last so it wins a collision
   always_comb
   begin
      state_nxt = state_r;
      if (host_req.we)
      begin
         state_nxt.mem[{host_req.slot, host_req.sel}] = host_req.wdata;
      end
      if (eng_wr.we1)
      begin
         state_nxt.mem[{eng_wr.slot, 2'h2}] = eng_wr.res1;
      end
      if (eng_wr.we2)
      begin
         state_nxt.mem[{eng_wr.slot, 2'h3}] = eng_wr.res2;
      end
      // Reads see the value before this cycle's write
      state_nxt.hrd = state_r.mem[{host_req.slot, host_req.sel}];
      state_nxt.erd = state_r.mem[{eng_slot, 2'h0} +: 4];
   end

   // Register the whole store
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign host_rdata = state_r.hrd;
   assign eng_words = state_r.erd;

   a_word_hold:
   assert property (@(posedge clk) disable iff (!rst_n)
      (!host_req.we && !eng_wr.we1 && !eng_wr.we2)
      |=> (state_r.mem == $past(state_r.mem)))
   else $error("slot word changed without a write");

endmodule
`default_nettype wire
